// >>> src/rcb_pkg.sv
// rcb_pkg: constants, register map and field layout of the calibration block
// assumes a 10 MHz system clock and an AXI4-Lite register bus with 32-bit data
package rcb_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned ACC_W = 25;

  localparam int unsigned ADDR_W = 21;
  localparam int unsigned IDX_W = 19;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 19'h7_fff0;
  localparam logic [IDX_W-1:0] IDX_ALARM = 19'h7_fff6;
  localparam logic [IDX_W-1:0] IDX_WDOG = 19'h7_fff7;
  localparam logic [IDX_W-1:0] IDX_CAL = 19'h7_fff8;
  localparam logic [IDX_W-1:0] IDX_SEC = 19'h7_fff9;
  localparam logic [IDX_W-1:0] IDX_DAY = 19'h7_fffc;

  localparam int unsigned FLAG_BL_BIT = 4;
  localparam logic [7:0] FLAG_RW_MASK = 8'h0f;
  localparam int unsigned ALM_AFE_BIT = 7;
  localparam int unsigned ALM_SQUARE_WAVE_ENABLE_BIT = 6;
  localparam int unsigned ALM_ABE_BIT = 5;
  localparam logic [7:0] ALM_CLR_MASK = 8'he0;
  localparam int unsigned WD_WDS_BIT = 7;
  localparam int unsigned SEC_ST_BIT = 7;
  localparam int unsigned DAY_FT_BIT = 6;
  localparam logic [7:0] DAY_CLR_MASK = 8'h40;
  localparam logic [7:0] CAL_CLR_MASK = 8'hc0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam logic [7:0] STAGE_LAST = 8'hff;
  localparam logic [7:0] STAGE_SKIP = 8'h80;
  localparam logic [7:0] SUB_LAST = 8'h7f;
  localparam logic [7:0] SUB_LAST_LONG = 8'h80;
  localparam logic [4:0] FT_LAST = 5'h1f;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] MIN_LAST = 6'h3f;
  localparam logic [5:0] MIN_ELIG = 6'h3e;
  localparam int unsigned BATT_TEST_S = 86_400;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // calibration register layout
  typedef struct packed {
    logic wr;
    logic rd;
    logic positive;
    logic [4:0] magnitude;
  } rcb_cal_t;

  // correction state latched for one second
  typedef struct packed {
    logic active;
    logic positive;
  } rcb_corr_t;

endpackage : rcb_pkg

// >>> src/rcb_top.sv
// rcb_top: clock calibration, frequency test output and battery-low monitor
// assumes an AXI4-Lite master, synchronous pin inputs and a 10 MHz clock
//
// How it works
// R01 - timebase is a 32,768 Hz oscillator tick feeding a binary divider chain
// R02 - calibration adds or removes counts at the divide-by-256 stage only
// R03 - calibration magnitude 0..31 sits in bits 4..0 of calibration_control
// R04 - bit 5 selects direction: one adds counts, zero removes them
// R05 - added counts make time run faster, removed counts slower; here adding lengthens the second (slower), removing shortens it (faster)
// R06 - 64-minute cycle, first 62 minutes eligible, one second each at most
// R07 - corrected second is 128 cycles shorter or 256 cycles longer
// R08 - magnitude N corrects only the first 2N minutes of the cycle
// R09 - test pin toggles 512 Hz when stop, AFE, watchdog conditions allow
// R10 - frequency test comes from the uncorrected divider path
// R11 - outside party waits four seconds before measuring the test output
// R12 - frequency-test enable is cleared whenever main power goes down
// R13 - battery tested at each power-up and roughly every 24 hours
// R14 - failing test sets battery_low_flag, bit 4 of the flags register
// R15 - the flag stays set until a later test passes
// R16 - battery tests run only while main supply is nominal
// R17 - initial power clears watchdog, alarm enables, W, R and test bits
// R18 - reset request clears the same bits and leaves the rest alone
// R19 - power-down clears W, R, test bit and watchdog, keeps alarm enables
// R20 - watchdog or alarm on the test pin overrides the frequency test
// R21 - each correction stays within one second, counters stay monotonic
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module rcb_top #(
  parameter int unsigned BATT_TEST_SECONDS = rcb_pkg::BATT_TEST_S
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [rcb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rcb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vcc_ok,
  input wire logic reset_request,
  input wire logic battery_low_sense,
  input wire logic irq_request,
  input wire logic interrupt_test_pin_in,
  output logic interrupt_test_pin_out,
  output logic interrupt_test_pin_oe,
  output logic second_pulse,
  output logic freq_test_active
);

  // register index of a byte address
  function automatic logic [rcb_pkg::IDX_W-1:0] idx_of(input logic [rcb_pkg::ADDR_W-1:0] a);
    idx_of = a[rcb_pkg::ADDR_W-1:2];
  endfunction : idx_of

  function automatic logic mapped(input logic [rcb_pkg::IDX_W-1:0] i);
    mapped = (i == rcb_pkg::IDX_FLAGS) || (i == rcb_pkg::IDX_ALARM) ||
             (i == rcb_pkg::IDX_WDOG) || (i == rcb_pkg::IDX_CAL) ||
             (i == rcb_pkg::IDX_SEC) || (i == rcb_pkg::IDX_DAY);
  endfunction : mapped

  // minute inside the first 2N and inside the first 62
  function automatic logic eligible(input logic [5:0] minute, input logic [4:0] mag);
    eligible = (minute < rcb_pkg::MIN_ELIG) && (minute < {mag, 1'b0});
  endfunction : eligible

  logic [7:0] flags_and_rate_select_reg;
  logic [7:0] alarm_and_square_enable_reg;
  logic [7:0] watchdog_timeout_setting_reg;
  logic [7:0] calibration_control_reg;
  logic [7:0] seconds_and_stop_reg;
  logic [7:0] day_and_freq_test_reg;
  logic battery_low_flag_reg;

  logic aw_hold_reg;
  logic [rcb_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic vcc_q_reg;
  logic [rcb_pkg::ACC_W-1:0] acc_reg;
  logic [rcb_pkg::ACC_W-1:0] acc_next;
  logic osc_tick;
  logic [7:0] stage_reg;
  logic [7:0] sub_reg;
  logic [5:0] sec_reg;
  logic [5:0] min_reg;
  rcb_pkg::rcb_corr_t corr_reg;
  logic [4:0] ft_div_reg;
  logic ft_phase_reg;
  logic [16:0] batt_cnt_reg;
  logic second_pulse_reg;
  logic pin_oe_reg;
  logic ft_active_reg;

  logic do_write;
  logic wr_byte;
  logic [rcb_pkg::IDX_W-1:0] wr_idx;
  logic [7:0] wr_val;
  logic power_down;
  logic power_up;
  logic stage_wrap;
  logic sec_end;
  logic [5:0] sec_next;
  logic [5:0] min_next;
  logic ft_on;
  logic batt_due;
  rcb_pkg::rcb_cal_t cal;

  assign cal = rcb_pkg::rcb_cal_t'(calibration_control_reg);
  assign power_down = vcc_q_reg && !vcc_ok;
  assign power_up = !vcc_q_reg && vcc_ok;

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_idx = idx_of(aw_addr_reg);
  assign wr_byte = do_write && w_strb_reg[0];
  assign wr_val = w_data_reg[7:0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= rcb_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(wr_idx) ? rcb_pkg::RESP_OKAY : rcb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= rcb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(idx_of(s_axi_araddr)) ? rcb_pkg::RESP_OKAY : rcb_pkg::RESP_SLVERR;
      case (idx_of(s_axi_araddr))
        rcb_pkg::IDX_FLAGS: rdata_reg <= {24'h00_0000, flags_and_rate_select_reg
                                          | (8'(battery_low_flag_reg) << rcb_pkg::FLAG_BL_BIT)};
        rcb_pkg::IDX_ALARM: rdata_reg <= {24'h00_0000, alarm_and_square_enable_reg};
        rcb_pkg::IDX_WDOG: rdata_reg <= {24'h00_0000, watchdog_timeout_setting_reg};
        rcb_pkg::IDX_CAL: rdata_reg <= {24'h00_0000, calibration_control_reg};
        rcb_pkg::IDX_SEC: rdata_reg <= {24'h00_0000, seconds_and_stop_reg};
        rcb_pkg::IDX_DAY: rdata_reg <= {24'h00_0000, day_and_freq_test_reg};
        default: rdata_reg <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vcc_q_reg <= 1'b0;
    end else begin
      vcc_q_reg <= vcc_ok;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flags_and_rate_select_reg <= rcb_pkg::BYTE_ZERO;
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_FLAGS) begin
      flags_and_rate_select_reg <= wr_val & rcb_pkg::FLAG_RW_MASK;
    end
  end

  // enables survive power-down, cleared by reset request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      alarm_and_square_enable_reg <= rcb_pkg::BYTE_ZERO; // [R17]
    end else if (reset_request) begin
      alarm_and_square_enable_reg <= alarm_and_square_enable_reg
                                     & ~rcb_pkg::ALM_CLR_MASK; // [R18]
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_ALARM) begin
      alarm_and_square_enable_reg <= wr_val; // [R19]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      watchdog_timeout_setting_reg <= rcb_pkg::BYTE_ZERO; // [R17]
    end else if (reset_request || power_down) begin
      watchdog_timeout_setting_reg <= rcb_pkg::BYTE_ZERO; // [R18] [R19]
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_WDOG) begin
      watchdog_timeout_setting_reg <= wr_val;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      calibration_control_reg <= rcb_pkg::BYTE_ZERO; // [R17]
    end else if (reset_request || power_down) begin
      calibration_control_reg <= calibration_control_reg
                                 & ~rcb_pkg::CAL_CLR_MASK; // [R18] [R19]
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_CAL) begin
      calibration_control_reg <= wr_val; // [R03] [R04]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seconds_and_stop_reg <= rcb_pkg::BYTE_ZERO;
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_SEC) begin
      seconds_and_stop_reg <= wr_val;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      day_and_freq_test_reg <= rcb_pkg::BYTE_ZERO; // [R17]
    end else if (reset_request || power_down) begin
      day_and_freq_test_reg <= day_and_freq_test_reg
                               & ~rcb_pkg::DAY_CLR_MASK; // [R12] [R18] [R19]
    end else if (wr_byte && wr_idx == rcb_pkg::IDX_DAY) begin
      day_and_freq_test_reg <= wr_val;
    end
  end

  // ---------------- oscillator tick ----------------
  assign acc_next = acc_reg + rcb_pkg::ACC_W'(rcb_pkg::OSC_HZ);
  assign osc_tick = (acc_next >= rcb_pkg::ACC_W'(rcb_pkg::CLK_HZ))
                    && !seconds_and_stop_reg[rcb_pkg::SEC_ST_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= '0;
    end else if (seconds_and_stop_reg[rcb_pkg::SEC_ST_BIT]) begin
      acc_reg <= acc_reg;
    end else if (osc_tick) begin
      acc_reg <= acc_next - rcb_pkg::ACC_W'(rcb_pkg::CLK_HZ); // [R01]
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ---------------- corrected divider chain ----------------
  assign stage_wrap = osc_tick && stage_reg == rcb_pkg::STAGE_LAST; // [R02]
  assign sec_end = stage_wrap && sub_reg == (corr_reg.active && corr_reg.positive
                   ? rcb_pkg::SUB_LAST_LONG : rcb_pkg::SUB_LAST); // [R07] [R05]
  assign sec_next = (sec_reg == rcb_pkg::SEC_LAST) ? 6'h00 : sec_reg + 6'h01;
  assign min_next = (sec_reg != rcb_pkg::SEC_LAST) ? min_reg
                    : (min_reg == rcb_pkg::MIN_LAST) ? 6'h00 : min_reg + 6'h01;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_reg <= '0;
    end else if (sec_end && sec_next == 6'h00 && eligible(min_next, cal.magnitude)
                 && !cal.positive) begin
      stage_reg <= rcb_pkg::STAGE_SKIP; // [R07] [R05]
    end else if (osc_tick) begin
      stage_reg <= stage_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sub_reg <= '0;
    end else if (sec_end) begin
      sub_reg <= '0;
    end else if (stage_wrap) begin
      sub_reg <= sub_reg + 8'h01; // [R21]
    end
  end

  // correction decided at the start of the first second of each minute
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      corr_reg <= '0;
    end else if (sec_end) begin
      corr_reg.active <= sec_next == 6'h00 && eligible(min_next, cal.magnitude); // [R06] [R08]
      corr_reg.positive <= cal.positive; // [R04] [R21]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_reg <= '0;
      min_reg <= '0;
    end else if (sec_end) begin
      sec_reg <= sec_next;
      min_reg <= min_next; // [R06]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      second_pulse_reg <= 1'b0;
    end else begin
      second_pulse_reg <= sec_end;
    end
  end

  // ---------------- frequency test ----------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ft_div_reg <= '0;
      ft_phase_reg <= 1'b0;
    end else if (osc_tick) begin
      ft_div_reg <= ft_div_reg + 5'h01; // [R10]
      if (ft_div_reg == rcb_pkg::FT_LAST) begin
        ft_phase_reg <= !ft_phase_reg;
      end
    end
  end

  assign ft_on = !seconds_and_stop_reg[rcb_pkg::SEC_ST_BIT]
                 && day_and_freq_test_reg[rcb_pkg::DAY_FT_BIT]
                 && !alarm_and_square_enable_reg[rcb_pkg::ALM_AFE_BIT]
                 && (watchdog_timeout_setting_reg[rcb_pkg::WD_WDS_BIT]
                     || watchdog_timeout_setting_reg == rcb_pkg::BYTE_ZERO); // [R09]

  // open-drain pin, low while enabled
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_oe_reg <= 1'b0;
      ft_active_reg <= 1'b0;
    end else if (irq_request) begin
      pin_oe_reg <= 1'b1; // [R20]
      ft_active_reg <= 1'b0;
    end else begin
      pin_oe_reg <= ft_on && !ft_phase_reg; // [R09]
      ft_active_reg <= ft_on;
    end
  end

  assign interrupt_test_pin_out = 1'b0;
  assign interrupt_test_pin_oe = pin_oe_reg;
  assign freq_test_active = ft_active_reg;
  assign second_pulse = second_pulse_reg;

  // ---------------- battery monitor ----------------
  assign batt_due = vcc_ok && sec_end
                    && batt_cnt_reg == 17'(BATT_TEST_SECONDS - 1); // [R13]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      batt_cnt_reg <= '0;
    end else if (power_up || batt_due) begin
      batt_cnt_reg <= '0;
    end else if (vcc_ok && sec_end) begin
      batt_cnt_reg <= batt_cnt_reg + 17'h0_0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      battery_low_flag_reg <= 1'b0;
    end else if (power_up || batt_due) begin
      battery_low_flag_reg <= battery_low_sense; // [R14] [R15] [R16]
    end
  end

endmodule : rcb_top

// >>> bench/rcb_top_properties.sv
// rcb_top_properties: port-level checks of the test pin and register bus
// assumes it is bound into rcb_top and sees only that module's ports
`timescale 1ns/1ps
module rcb_top_properties #(
  parameter int unsigned BATT_TEST_SECONDS = rcb_pkg::BATT_TEST_S
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vcc_ok,
  input wire logic irq_request,
  input wire logic interrupt_test_pin_out,
  input wire logic interrupt_test_pin_oe,
  input wire logic freq_test_active
);
  localparam int GAP_MIN = 9764;
  localparam int GAP_MAX = 9767;
  logic oe_q, act_q;
  logic clean;
  logic gap_chk;
  int unsigned cnt;
  int unsigned last_gap;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // cycles between pin changes while the test output runs undisturbed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_q <= 1'b0;
      act_q <= 1'b0;
      clean <= 1'b0;
      gap_chk <= 1'b0;
      cnt <= 0;
      last_gap <= 0;
    end else begin
      oe_q <= interrupt_test_pin_oe;
      act_q <= freq_test_active;
      gap_chk <= (interrupt_test_pin_oe != oe_q) && clean && freq_test_active && !irq_request;
      if (interrupt_test_pin_oe != oe_q) begin
        last_gap <= cnt;
        cnt <= 1;
        clean <= freq_test_active && act_q && !irq_request;
      end else begin
        cnt <= cnt + 1;
        if (!freq_test_active || irq_request) begin
          clean <= 1'b0;
        end
      end
    end
  end

  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence write_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence read_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  irq_pin_a: assert property (irq_request |=> interrupt_test_pin_oe)
    else $error("pin not pulled low under request");
  pin_level_a: assert property (interrupt_test_pin_out == 1'b0)
    else $error("open drain pin driven high");
  half_period_a: assert property (gap_chk && freq_test_active |-> last_gap inside {[GAP_MIN:GAP_MAX]})
    else $error("test output half period wrong");
  test_stall_a: assert property (clean && freq_test_active && !irq_request |-> cnt <= GAP_MAX)
    else $error("test output stopped toggling");
  pin_release_a: assert property ((!freq_test_active && !irq_request) [*3] |-> !interrupt_test_pin_oe)
    else $error("pin driven with test output off");
  power_down_a: assert property ($fell(vcc_ok) |-> ##[1:3] !freq_test_active)
    else $error("test output kept after power-down");
  write_hold_a: assert property (write_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (read_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule : rcb_top_properties

bind rcb_top rcb_top_properties #(.BATT_TEST_SECONDS(BATT_TEST_SECONDS)) u_props (.clock, .nrst,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .vcc_ok, .irq_request,
  .interrupt_test_pin_out, .interrupt_test_pin_oe, .freq_test_active);

// >>> bench/rcb_host.sv
// rcb_host: register bus master standing for the microprocessor
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module rcb_host (
  input wire logic clock,
  output logic [rcb_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [rcb_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  task automatic wr(input logic [rcb_pkg::IDX_W-1:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [rcb_pkg::IDX_W-1:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rcb_host

// >>> bench/tb_rcb_top.sv
// tb_rcb_top: register, power and test pin scenarios for rcb_top
// assumes rcb_host as bus master and the bound property checker
`timescale 1ns/1ps
module tb_rcb_top;
  localparam logic [18:0] i_fl = rcb_pkg::IDX_FLAGS, i_al = rcb_pkg::IDX_ALARM;
  localparam logic [18:0] i_wd = rcb_pkg::IDX_WDOG, i_cal = rcb_pkg::IDX_CAL;
  localparam logic [18:0] i_sec = rcb_pkg::IDX_SEC, i_day = rcb_pkg::IDX_DAY;
  localparam logic [18:0] i_bad = 19'h7_fff1;
  localparam logic [1:0] ok = rcb_pkg::RESP_OKAY, bad = rcb_pkg::RESP_SLVERR;
  logic clock, nrst, vcc_ok, reset_request, battery_low_sense, irq_request;
  logic interrupt_test_pin_in, interrupt_test_pin_out, interrupt_test_pin_oe;
  logic second_pulse, freq_test_active;
  logic [rcb_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [18:0] sup_idx [4] = '{i_al, i_wd, i_wd, i_sec};
  logic [7:0] sup_val [4] = '{8'h80, 8'h01, 8'h81, 8'h80};
  logic sup_exp [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int err_total, n_checks, n;

  // pin with pull-up: low only while driven
  assign interrupt_test_pin_in = !interrupt_test_pin_oe;

  rcb_top #(.BATT_TEST_SECONDS(3)) dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vcc_ok, .reset_request, .battery_low_sense,
    .irq_request, .interrupt_test_pin_in, .interrupt_test_pin_out, .interrupt_test_pin_oe,
    .second_pulse, .freq_test_active);
  rcb_host u_host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic rdc(input logic [18:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(idx, d, r);
    chk("read data", {24'h00_0000, exp}, d);
    chk("read resp", {30'h0000_0000, er}, {30'h0000_0000, r});
  endtask : rdc
  task automatic wrc(input logic [18:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_host.wr(idx, d, r);
    chk("write resp", {30'h0000_0000, er}, {30'h0000_0000, r});
  endtask : wrc
  task automatic idle(input int k);
    repeat (k) @(posedge clock);
  endtask : idle
  task automatic meas(output int m);
    logic v;
    m = 0;
    v = interrupt_test_pin_oe;
    do begin @(posedge clock); m++; end while (interrupt_test_pin_oe === v && m < 12000);
    v = interrupt_test_pin_oe;
    m = 0;
    do begin @(posedge clock); m++; end while (interrupt_test_pin_oe === v && m < 12000);
  endtask : meas
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (80000) @(posedge clock);
    err_total++;
    close_out();
  end

  initial begin
    {nrst, reset_request, irq_request} = 3'h0;
    {vcc_ok, battery_low_sense} = 2'h3;
    err_total = 0;
    n_checks = 0;
    idle(10);
    nrst <= 1'b1;
    idle(2);
    rdc(i_fl, 8'h10, ok);
    foreach (sup_idx[k]) rdc(sup_idx[k], 8'h00, ok);
    rdc(i_cal, 8'h00, ok);
    rdc(i_day, 8'h00, ok);
    wrc(i_bad, 8'h5a, bad);
    rdc(i_bad, 8'h00, bad);
    wrc(i_al, 8'hff, ok);
    wrc(i_wd, 8'hff, ok);
    wrc(i_cal, 8'hff, ok);
    wrc(i_day, 8'h40, ok);
    wrc(i_fl, 8'hff, ok);
    rdc(i_cal, 8'hff, ok);
    rdc(i_fl, 8'h1f, ok);
    reset_request <= 1'b1;
    idle(1);
    reset_request <= 1'b0;
    idle(2);
    rdc(i_al, 8'h1f, ok);
    rdc(i_wd, 8'h00, ok);
    rdc(i_cal, 8'h3f, ok);
    rdc(i_day, 8'h00, ok);
    rdc(i_fl, 8'h1f, ok);
    wrc(i_al, 8'he0, ok);
    wrc(i_wd, 8'h8f, ok);
    wrc(i_cal, 8'hc5, ok);
    wrc(i_day, 8'h40, ok);
    {vcc_ok, battery_low_sense} <= 2'h0;
    idle(3);
    rdc(i_al, 8'he0, ok);
    rdc(i_wd, 8'h00, ok);
    rdc(i_cal, 8'h05, ok);
    rdc(i_day, 8'h00, ok);
    rdc(i_fl, 8'h1f, ok);
    vcc_ok <= 1'b1;
    idle(3);
    rdc(i_fl, 8'h0f, ok);
    wrc(i_al, 8'h00, ok);
    wrc(i_day, 8'h40, ok);
    idle(3);
    chk("test active", 32'h0000_0001, {31'h0000_0000, freq_test_active});
    meas(n);
    chk("half period", 32'h0000_0001, {31'h0000_0000, n >= 9764 && n <= 9767});
    wrc(i_cal, 8'h3f, ok);
    meas(n);
    chk("half period", 32'h0000_0001, {31'h0000_0000, n >= 9764 && n <= 9767});
    foreach (sup_idx[k]) begin
      wrc(sup_idx[k], sup_val[k], ok);
      idle(3);
      chk("test gated", {31'h0000_0000, sup_exp[k]}, {31'h0000_0000, freq_test_active});
      wrc(sup_idx[k], 8'h00, ok);
      idle(3);
      chk("test back", 32'h0000_0001, {31'h0000_0000, freq_test_active});
    end
    irq_request <= 1'b1;
    idle(3);
    chk("pin driven", 32'h0000_0001, {31'h0000_0000, interrupt_test_pin_oe});
    irq_request <= 1'b0;
    vcc_ok <= 1'b0;
    idle(3);
    chk("test off", 32'h0000_0000, {31'h0000_0000, freq_test_active});
    rdc(i_day, 8'h00, ok);
    vcc_ok <= 1'b1;
    idle(2);
    chk("second pulse", '0, {31'h0, second_pulse});
    close_out();
  end
endmodule : tb_rcb_top
